// *** src/scs_clock_select.v ***
// Purpose: system clock source select with external-source failover and bus prescalers
// Assumes: oscillator activity arrives as asynchronous levels; one sys_clk domain
// Notes: the clock tree itself is steered by sysClkSrc and gate outputs plus bus enables
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "scs_clock_select_defs.vh"

module scs_clock_select (
  input wire sys_clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire extOscIn,
  input wire pllLockIn,
  output wire [1:0] sysClkSrc,
  output wire sysClkGate,
  output wire pllEnable,
  output wire pllSrcExt,
  output wire [4:0] pllMul,
  output wire [2:0] busClkEn,
  output wire usbClkOk,
  output wire irq
);

  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_GATE = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_OPEN = 4'h8;

  reg [31:0] ctrl_q;
  reg [8:0] presc_q;
  reg [2:0] irqStat_q;
  reg [2:0] irqEn_q;
  reg ack_q;
  reg [31:0] rdat_q;
  reg extSync1_q, extSync2_q, extPrev_q;
  reg lockSync1_q, lockSync2_q;
  reg [7:0] monCnt_q;
  reg extFail_q;
  reg [3:0] state_q;
  reg [1:0] actSrc_q;
  reg gate_q;
  reg [3:0] gapCnt_q;
  reg [2:0] busEn_q;

  wire busReq = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wrReq = busReq & wb_we_i;
  wire [1:0] reqSrc = ctrl_q[`SCS_CTRL_SRC_HI:`SCS_CTRL_SRC_LO];
  wire pllEn = ctrl_q[`SCS_CTRL_PLL_EN];
  wire pllExt = ctrl_q[`SCS_CTRL_PLL_EXT];
  wire [4:0] extMhz = ctrl_q[`SCS_CTRL_EXTF_HI:`SCS_CTRL_EXTF_LO];
  wire [3:0] mulField = ctrl_q[`SCS_CTRL_MUL_HI:`SCS_CTRL_MUL_LO];

  // multiplier below 2 is not a legal PLL setting, so it is lifted to 2;
  // the top code stands for x16, the only way the 4 bit field can reach 64 MHz
  // from the halved rc, which keeps that ceiling reachable and not just a bound
  wire [4:0] mulEff = (mulField < 4'h2) ? 5'h02 :
                      (mulField == 4'hf) ? 5'h10 : {1'b0, mulField};
  // rc enters the PLL halved, so 4 MHz x 16 caps it at 64 MHz
  wire [4:0] pllInMhz = pllExt ? extMhz : `SCS_RC_PLL_IN_MHZ;
  wire [9:0] pllMhz = pllInMhz * mulEff;
  wire extUsed = (reqSrc == `SCS_SRC_EXT) | (pllEn & pllExt);
  wire extRangeOk = (extMhz >= `SCS_EXT_MIN_MHZ) & (extMhz <= `SCS_EXT_MAX_MHZ);
  wire pllOk = pllEn & lockSync2_q & (pllMhz <= `SCS_FAST_MAX_MHZ)
               & ~(pllExt & (extFail_q | ~extRangeOk));
  reg [1:0] tgtSrc;

  // target source: a failed or unusable source falls back to the rc
  always @* begin
    tgtSrc = `SCS_SRC_RC;
    case (reqSrc)
      `SCS_SRC_EXT: tgtSrc = (extFail_q | ~extRangeOk) ? `SCS_SRC_RC : `SCS_SRC_EXT;
      `SCS_SRC_PLL: tgtSrc = pllOk ? `SCS_SRC_PLL : `SCS_SRC_RC;
      default: tgtSrc = `SCS_SRC_RC;
    endcase
  end

  // frequency of the running source and of each bus
  wire [9:0] sysMhz = (actSrc_q == `SCS_SRC_PLL) ? pllMhz :
                      (actSrc_q == `SCS_SRC_EXT) ? {5'h00, extMhz} : {2'h0, `SCS_RC_MHZ};
  wire [9:0] ahbMhz = sysMhz >> presc_q[2:0];
  wire [9:0] fastMhz = ahbMhz >> presc_q[5:3];
  // slow bus divider raised by one step when software leaves it too fast;
  // a silent raise beats a slow bus running over its ceiling, but software
  // reading the status word sees the raised divider applied to the system bus, while the slow enable divides sys_clk
  wire [2:0] slowShift = (((ahbMhz >> presc_q[8:6]) > `SCS_SLOW_MAX_MHZ) & (presc_q[8:6] != 3'h7))
                         ? (presc_q[8:6] + 3'h1) : presc_q[8:6];
  wire [9:0] slowMhz = ahbMhz >> slowShift;
  // usb is only flagged when the external source really feeds a locked PLL at 48 MHz
  wire usbOk = extUsed & ~extFail_q & pllOk & pllExt & (pllMhz == `SCS_USB_MHZ);
  // converter timing only holds at these three fast bus rates
  wire adcOk = (fastMhz == `SCS_ADC_A_MHZ) | (fastMhz == `SCS_ADC_B_MHZ)
               | (fastMhz == `SCS_ADC_C_MHZ);

  // oscillator activity and lock come from outside: two flops first
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
      extPrev_q <= 1'b0;
      lockSync1_q <= 1'b0;
      lockSync2_q <= 1'b0;
    end else begin
      extSync1_q <= extOscIn;
      extSync2_q <= extSync1_q;
      extPrev_q <= extSync2_q;
      lockSync1_q <= pllLockIn;
      lockSync2_q <= lockSync1_q;
    end
  end

  // failure monitor: no edge within the timeout while the source is in use.
  // the timeout is far longer than the slowest legal oscillator half period,
  // so a live source never trips it; a source stuck at either level does.
  // the counter is held at zero while the source is unused, so switching to it
  // always starts a fresh window rather than inheriting a stale count
  wire extEdge = extSync2_q ^ extPrev_q;
  wire monHit = extUsed & ~extFail_q & ~extEdge
                & (monCnt_q == (`SCS_MON_TIMEOUT_CYC - 1));
  wire failClr = wrReq & (wb_adr_i == `SCS_REG_IRQ_CLR) & wb_sel_i[0] & wb_dat_i[`SCS_IRQ_EXT_FAIL];
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      monCnt_q <= 8'h00;
      extFail_q <= 1'b0;
    end else begin
      if (!extUsed || extEdge || extFail_q)
        monCnt_q <= 8'h00;
      else if (!monHit)
        monCnt_q <= monCnt_q + 8'h01;
      // failure holds the source off until software clears the event
      if (monHit)
        extFail_q <= 1'b1;
      else if (failClr)
        extFail_q <= 1'b0;
    end
  end

  // break-before-make switch: gate closes, settles, source moves, gate reopens.
  // the gate is closed for both gaps, so no shortened pulse of either source
  // can leak out; the cost is about ten cycles with no clock at each switch.
  // a target that changes during the first gap is taken up at the move; a later change waits for the next pass
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_RUN;
      actSrc_q <= `SCS_SRC_RC;
      gate_q <= 1'b1;
      gapCnt_q <= 4'h0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (tgtSrc != actSrc_q) begin
            gate_q <= 1'b0;
            gapCnt_q <= 4'h0;
            state_q <= ST_GATE;
          end
        end
        ST_GATE: begin
          if (gapCnt_q == (`SCS_SW_GAP_CYC - 1)) begin
            actSrc_q <= tgtSrc;
            gapCnt_q <= 4'h0;
            state_q <= ST_WAIT;
          end else
            gapCnt_q <= gapCnt_q + 4'h1;
        end
        ST_WAIT: begin
          // second quiet gap lets the new source settle before it is passed on
          if (gapCnt_q == (`SCS_SW_GAP_CYC - 1))
            state_q <= ST_OPEN;
          else
            gapCnt_q <= gapCnt_q + 4'h1;
        end
        ST_OPEN: begin
          gate_q <= 1'b1;
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
          gate_q <= 1'b1;
        end
      endcase
    end
  end

  // per-bus divider enables, one pulse every 2^shift cycles, held while gated.
  // the enables are cleared on the same edge that closes the gate, so no bus
  // sees a last pulse while the clock is already shut off
  wire gateClosing = (state_q == ST_RUN) & (tgtSrc != actSrc_q);
  wire [8:0] busShift = {slowShift, presc_q[2:0] + presc_q[5:3], presc_q[2:0]};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gBus
      reg [7:0] divCnt_q;
      wire [2:0] shiftI = busShift[gi*3+2:gi*3];
      wire [7:0] lastCnt = (8'h01 << shiftI) - 8'h01;
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          divCnt_q <= 8'h00;
          busEn_q[gi] <= 1'b0;
        end else if (!gate_q || gateClosing) begin
          divCnt_q <= 8'h00;
          busEn_q[gi] <= 1'b0;
        end else begin
          divCnt_q <= (divCnt_q >= lastCnt) ? 8'h00 : divCnt_q + 8'h01;
          busEn_q[gi] <= (divCnt_q >= lastCnt);
        end
      end
    end
  endgenerate

  // events: set wins over a clear in the same cycle, so a failure that lands
  // while software clears an older one is never lost.
  // the PLL event is the external failure seen while that source feeds the PLL
  wire [2:0] evt;
  assign evt[`SCS_IRQ_EXT_FAIL] = monHit;
  assign evt[`SCS_IRQ_PLL_FAIL] = monHit & pllEn & pllExt;
  assign evt[`SCS_IRQ_SWITCHED] = (state_q == ST_OPEN);
  wire [2:0] clrMask = (wrReq && (wb_adr_i == `SCS_REG_IRQ_CLR) && wb_sel_i[0])
                       ? wb_dat_i[2:0] : 3'h0;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      irqStat_q <= 3'h0;
    else
      irqStat_q <= (irqStat_q & ~clrMask) | evt;
  end

  // register writes, byte lanes honoured; status and event words ignore writes
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `SCS_CTRL_RESET;
      presc_q <= 9'h000;
      irqEn_q <= 3'h0;
    end else if (wrReq) begin
      case (wb_adr_i)
        `SCS_REG_CTRL: begin
          if (wb_sel_i[0])
            ctrl_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            ctrl_q[12:8] <= wb_dat_i[12:8];
        end
        `SCS_REG_PRESC: begin
          if (wb_sel_i[0])
            presc_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            presc_q[8] <= wb_dat_i[8];
        end
        `SCS_REG_IRQ_EN: begin
          if (wb_sel_i[0])
            irqEn_q <= wb_dat_i[2:0];
        end
        default: ;
      endcase
    end
  end

  // one-cycle ack per access; unmapped reads return zero
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= busReq;
      if (busReq && !wb_we_i) begin
        case (wb_adr_i)
          `SCS_REG_CTRL: rdat_q <= {19'h00000, ctrl_q[12:0]};
          `SCS_REG_PRESC: rdat_q <= {23'h000000, presc_q};
          `SCS_REG_STATUS: rdat_q <= {sysMhz[7:0], slowMhz[7:0], 8'h00, gate_q, adcOk,
                                      usbOk, extFail_q, lockSync2_q, extUsed, actSrc_q};
          `SCS_REG_IRQ_STAT: rdat_q <= {29'h00000000, irqStat_q};
          `SCS_REG_IRQ_EN: rdat_q <= {29'h00000000, irqEn_q};
          default: rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign sysClkSrc = actSrc_q;
  assign sysClkGate = gate_q;
  assign pllEnable = pllEn;
  assign pllSrcExt = pllExt;
  assign pllMul = mulEff;
  assign busClkEn = busEn_q;
  assign usbClkOk = usbOk;
  assign irq = |(irqStat_q & irqEn_q);

endmodule // scs_clock_select

// *** pkg/scs_clock_select_defs.vh ***
// Purpose: constants for the system clock select and failover block
// Assumes: 100 MHz sys_clk, word-aligned classic Wishbone register map
// Notes: frequencies are whole MHz; times are in ns
// Function
// - every reset selects the internal 8 MHz RC oscillator as the system clock source.
// - software may select the external 4-16 MHz source, which is monitored while in use.
// - a detected external failure switches the system clock back to the internal RC by itself.
// - an external failure raises the interrupt only when its enable bit is set.
// - a failure of the external source feeding the PLL is signalled as its own interrupt.
// - separate prescalers derive the system-bus, fast and slow peripheral-bus clocks.
// - the system-bus and fast peripheral-bus clocks never exceed 72 MHz.
// - the slow peripheral-bus clock stays within 36 MHz only with the system bus undivided.
// - with the internal RC feeding the PLL the system clock reaches at most 64 MHz.
// - USB is usable only with external oscillator and PLL on and a 48 MHz USB kernel clock.
// - a 1 us converter time needs the fast peripheral bus at 14, 28 or 56 MHz.
`ifndef SCS_CLOCK_SELECT_DEFS_VH
`define SCS_CLOCK_SELECT_DEFS_VH

// register byte offsets
`define SCS_REG_CTRL 6'h00
`define SCS_REG_PRESC 6'h04
`define SCS_REG_STATUS 6'h08
`define SCS_REG_IRQ_STAT 6'h0c
`define SCS_REG_IRQ_EN 6'h10
`define SCS_REG_IRQ_CLR 6'h14

// control fields
`define SCS_CTRL_SRC_LO 0
`define SCS_CTRL_SRC_HI 1
`define SCS_CTRL_PLL_EN 2
`define SCS_CTRL_PLL_EXT 3
`define SCS_CTRL_MUL_LO 4
`define SCS_CTRL_MUL_HI 7
`define SCS_CTRL_EXTF_LO 8
`define SCS_CTRL_EXTF_HI 12
`define SCS_CTRL_RESET 32'h0000_0890

// source codes
`define SCS_SRC_RC 2'h0
`define SCS_SRC_EXT 2'h1
`define SCS_SRC_PLL 2'h2

// interrupt bits
`define SCS_IRQ_EXT_FAIL 0
`define SCS_IRQ_PLL_FAIL 1
`define SCS_IRQ_SWITCHED 2

// frequencies in MHz
`define SCS_RC_MHZ 8'h08
`define SCS_RC_PLL_IN_MHZ 5'h04
`define SCS_EXT_MIN_MHZ 5'h04
`define SCS_EXT_MAX_MHZ 5'h10
`define SCS_FAST_MAX_MHZ 10'h048
`define SCS_SLOW_MAX_MHZ 10'h024
`define SCS_USB_MHZ 10'h030
`define SCS_ADC_A_MHZ 10'h00e
`define SCS_ADC_B_MHZ 10'h01c
`define SCS_ADC_C_MHZ 10'h038

// timing
`define SCS_CLK_PERIOD_NS 10
`define SCS_MON_TIMEOUT_NS 1000
`define SCS_MON_TIMEOUT_CYC (`SCS_MON_TIMEOUT_NS / `SCS_CLK_PERIOD_NS)
`define SCS_SW_GAP_NS 40
`define SCS_SW_GAP_CYC (`SCS_SW_GAP_NS / `SCS_CLK_PERIOD_NS)

`endif

// *** testbench/scs_clock_select_asserts.sv ***
// Purpose: port-level checks for the clock select block
// Assumes: bound to scs_clock_select; one sys_clk domain
// Notes: quietCnt_q counts cycles with no edge on extOscIn
`timescale 1ns/1ps
`include "scs_clock_select_defs.vh"
module scs_clock_select_asserts (
  input wire sys_clk,
  input wire arst_n,
  input wire extOscIn,
  input wire [1:0] sysClkSrc,
  input wire sysClkGate,
  input wire pllEnable,
  input wire pllSrcExt,
  input wire [2:0] busClkEn,
  input wire usbClkOk
);
  reg extPrev_q;
  reg [7:0] quietCnt_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // saturates so a dead source stays visible past the monitor limit
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      extPrev_q <= 1'b0;
      quietCnt_q <= 8'h00;
    end else begin
      extPrev_q <= extOscIn;
      quietCnt_q <= (extOscIn != extPrev_q) ? 8'h00 : quietCnt_q + {7'h00, quietCnt_q != 8'hff};
    end
  end
  // a switch keeps the gate shut for at least four edges, then reopens it within 6 to 12
  sequence gateShut; !sysClkGate [*4]; endsequence
  sequence gateBack; ##[6:12] sysClkGate; endsequence
  a_reset_picks_rc: assert property ($rose(arst_n) |-> sysClkSrc == `SCS_SRC_RC)
    else $error("source after reset is not RC");
  a_ext_fail_back: assert property ((sysClkSrc == `SCS_SRC_EXT && quietCnt_q == 8'h6e)
    |-> ##[0:20] sysClkSrc == `SCS_SRC_RC)
    else $error("dead external source kept");
  a_pll_fail_back: assert property ((sysClkSrc == `SCS_SRC_PLL && pllSrcExt
    && quietCnt_q == 8'h6e) |-> ##[0:20] sysClkSrc == `SCS_SRC_RC)
    else $error("dead source behind PLL kept");
  a_gate_held_low: assert property ($fell(sysClkGate) |-> gateShut)
    else $error("gate reopened early");
  a_gate_reopens: assert property ($fell(sysClkGate) |-> gateBack)
    else $error("gate stayed shut");
  a_src_under_gate: assert property ($changed(sysClkSrc) |-> !sysClkGate)
    else $error("source moved with gate open");
  a_bus_quiet_gate: assert property (!sysClkGate |-> busClkEn == 3'h0)
    else $error("bus enable while gated");
  a_usb_needs_ext: assert property (usbClkOk |-> pllEnable && pllSrcExt)
    else $error("usb ok without external PLL");
endmodule // scs_clock_select_asserts

bind scs_clock_select scs_clock_select_asserts u_chk (.sys_clk, .arst_n, .extOscIn,
  .sysClkSrc, .sysClkGate, .pllEnable, .pllSrcExt, .busClkEn, .usbClkOk);

// *** testbench/scs_ext_osc_model.sv ***
// Purpose: external high-speed oscillator and PLL lock source
// Assumes: run is a level from the bench
// Notes: a stopped oscillator freezes at its last level, as a dead crystal does
`timescale 1ns/1ps
module scs_ext_osc_model (
  input wire run,
  input wire pllEnable,
  output reg extOscIn,
  output wire pllLockIn
);
  parameter real HALF_NS = 62.5; // 8 MHz, inside the 4-16 MHz range
  // toggles only while running; failure is a stop
  initial begin
    extOscIn = 1'b0;
    forever begin
      #(HALF_NS);
      if (run) extOscIn = ~extOscIn;
    end
  end
  // lock needs settling time, never immediate
  assign #200 pllLockIn = pllEnable;
endmodule // scs_ext_osc_model

// *** testbench/scs_clock_select_bench.sv ***
// Purpose: self-checking bench for the clock select block
// Assumes: 100 MHz sys_clk, classic Wishbone single cycles
// Notes: stopping the oscillator model forces failover
`timescale 1ns/1ps
`include "scs_clock_select_defs.vh"
module scs_clock_select_bench;
  reg sys_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_we_i = 1'b0, oscRun = 1'b0;
  reg [5:0] wb_adr_i = 6'h00;
  reg [31:0] wb_dat_i = 32'h0, rdat;
  reg [69:0] rows [0:5];
  wire [31:0] wb_dat_o;
  wire [1:0] sysClkSrc;
  wire [2:0] busClkEn;
  wire [4:0] pllMul;
  wire sysClkGate;
  wire wb_ack_o, extOscIn, pllLockIn, pllEnable, usbClkOk, irq;
  integer fails = 0, checked = 0, i, n;
  scs_clock_select u_scs_clock_select (.sys_clk, .arst_n, .wb_cyc_i, .wb_stb_i(wb_cyc_i),
    .wb_we_i, .wb_adr_i, .wb_sel_i(4'h3), .wb_dat_i, .wb_dat_o, .wb_ack_o, .extOscIn,
    .pllLockIn, .sysClkSrc, .sysClkGate, .pllEnable, .pllSrcExt(), .pllMul,
    .busClkEn, .usbClkOk, .irq);
  scs_ext_osc_model u_scs_ext_osc_model (.run(oscRun), .pllEnable, .extOscIn, .pllLockIn);
  // free-running system clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    begin
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task limit(input integer lim);
    if (n >= lim) begin
      fails = fails + 1;
      report_and_stop;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge sys_clk);
  endtask
  // one classic cycle; read data is taken at the ack edge only
  task bus(input w, input [5:0] a, input [31:0] d);
    begin
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge sys_clk);
      for (n = 0; n < 20 && wb_ack_o !== 1'b1; n = n + 1) @(posedge sys_clk);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      limit(20);
      @(posedge sys_clk);
    end
  endtask
  // a switch takes about ten cycles; failover adds the monitor time
  task waitSrc(input [1:0] s);
    begin
      for (n = 0; n < 300 && sysClkSrc !== s; n = n + 1) @(posedge sys_clk);
      limit(300);
      tick(8);
    end
  endtask
  // address, mask, expected read value
  initial begin
    rows[0] = {`SCS_REG_CTRL, 32'hffffffff, `SCS_CTRL_RESET};
    rows[1] = {`SCS_REG_STATUS, 32'hff000083, 32'h08000080};
    rows[2] = {`SCS_REG_IRQ_STAT, 32'hffffffff, 32'h0};
    rows[3] = {`SCS_REG_IRQ_EN, 32'hffffffff, 32'h0};
    rows[4] = {`SCS_REG_IRQ_CLR, 32'hffffffff, 32'h0};
    rows[5] = {6'h3c, 32'hffffffff, 32'h0};
    tick(8);
    arst_n <= 1'b1;
    tick(1);
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'b0, rows[i][69:64], 32'h0);
      check(rdat & rows[i][63:32], rows[i][31:0]);
    end
    check({27'h0, pllMul}, 32'h9);
    check({31'h0, sysClkGate}, 32'h1);
    // system bus divided by two: 8 enables in 16 cycles
    bus(1'b1, `SCS_REG_PRESC, 32'h1);
    tick(4);
    i = 0;
    repeat (16) begin
      @(posedge sys_clk);
      i = i + busClkEn[0];
    end
    check(i, 32'h8);
    bus(1'b1, `SCS_REG_PRESC, 32'h0);
    $display("reset values done");
    // failover with the interrupt masked, then unmasked and cleared
    oscRun <= 1'b1;
    bus(1'b1, `SCS_REG_CTRL, 32'h00000891);
    waitSrc(`SCS_SRC_EXT);
    check({30'h0, sysClkSrc}, 32'h1);
    bus(1'b1, `SCS_REG_IRQ_CLR, 32'h7);
    oscRun <= 1'b0;
    waitSrc(`SCS_SRC_RC);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `SCS_REG_CTRL, 32'h00000890);
    bus(1'b1, `SCS_REG_IRQ_EN, 32'h1);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, `SCS_REG_IRQ_CLR, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("failover done");
    // PLL from the external source: 72 MHz, then 48 MHz for usb
    oscRun <= 1'b1;
    bus(1'b1, `SCS_REG_CTRL, 32'h0000089e);
    waitSrc(`SCS_SRC_PLL);
    bus(1'b0, `SCS_REG_STATUS, 32'h0);
    check(rdat & 32'hffff0000, 32'h48240000);
    bus(1'b1, `SCS_REG_CTRL, 32'h0000086e);
    tick(20);
    check({31'h0, usbClkOk}, 32'h1);
    bus(1'b1, `SCS_REG_IRQ_EN, 32'h2);
    oscRun <= 1'b0;
    waitSrc(`SCS_SRC_RC);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, `SCS_REG_CTRL, 32'h00000890);
    bus(1'b1, `SCS_REG_IRQ_CLR, 32'h7);
    $display("external PLL done");
    // RC into the PLL at the largest multiplier
    bus(1'b1, `SCS_REG_CTRL, 32'h000008f6);
    waitSrc(`SCS_SRC_PLL);
    bus(1'b0, `SCS_REG_STATUS, 32'h0);
    check(rdat & 32'hff000000, 32'h40000000);
    $display("RC PLL done");
    // reset in mid-run returns to RC and the reset control value
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    tick(1);
    check({30'h0, sysClkSrc}, 32'h0);
    bus(1'b0, `SCS_REG_CTRL, 32'h0);
    check(rdat, `SCS_CTRL_RESET);
    $display("second reset done");
    report_and_stop;
  end
endmodule // scs_clock_select_bench
